// File: common/psm_map.vh
/*
  Constants for the power-save mode controller: instruction operands,
  state codes, oscillator field layout and reset values.
  Assumes it is included by bare name, once per compilation unit or guarded.
*/
`ifndef PSM_MAP_VH
`define PSM_MAP_VH

// Power-save instruction operand codes
`define PSM_OP_SLEEP        1'h0
`define PSM_OP_IDLE         1'h1

// Controller state codes
`define PSM_ST_RUN          2'h0
`define PSM_ST_SLEEP        2'h1
`define PSM_ST_IDLE         2'h2
`define PSM_ST_WAKE         2'h3

// New-oscillator select field inside the oscillator control word
`define PSM_NOSC_MSB        10
`define PSM_NOSC_LSB        8
`define PSM_NOSC_W          3
`define PSM_NOSC_RST        3'h0

// Cycles the wake state lasts before the processor clock is given back
`define PSM_WAKE_CYC        8'h01

`endif

// File: sim/psm_asserts.sv
/* Checker for the power-save controller.
   Bound to the top module's ports. */
`timescale 1ns/1ps
module psm_asserts(
  input wire logic clk, rst, powerSaveInstr, powerSaveOperand, intPending, intEnabled, wdtTimeout,
  input wire logic oscCtrlWrite, cfgLocked, cpuClkEn_q, periphClkEn_q, sysClkEn_q, inSleep_q,
  input wire logic inIdle_q, wakePulse_q, wakeIntService_q, oscWriteRefused,
  input wire logic [15:0] oscCtrlWdata,
  input wire logic [2:0] newOscillatorSelect);
  wire logic lowPwr = inSleep_q | inIdle_q;
  wire logic [2:0] wrField = oscCtrlWdata[10:8];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sleep_entry: assert property (cpuClkEn_q && powerSaveInstr && !powerSaveOperand
    |=> inSleep_q && !sysClkEn_q && !periphClkEn_q && !cpuClkEn_q) else $error("sleep entry");
  chk_idle_entry: assert property (cpuClkEn_q && powerSaveInstr && powerSaveOperand
    |=> inIdle_q && periphClkEn_q && !cpuClkEn_q) else $error("idle entry");
  chk_entry_cause: assert property ($rose(lowPwr) |-> $past(powerSaveInstr)) else $error("entry");
  chk_wake_exit: assert property (lowPwr && (wdtTimeout || intPending && intEnabled)
    |=> (wakePulse_q && !lowPwr) ##1 cpuClkEn_q) else $error("wake");
  chk_int_service: assert property (lowPwr && intPending && intEnabled |-> ##2 wakeIntService_q)
    else $error("service");
  chk_osc_lock: assert property (oscCtrlWrite && cfgLocked |=> oscWriteRefused && $stable(newOscillatorSelect))
    else $error("lock");
  chk_osc_write: assert property (oscCtrlWrite && !cfgLocked |=> newOscillatorSelect == $past(wrField))
    else $error("write");
  chk_masked_hold: assert property (lowPwr && !wdtTimeout && !(intPending && intEnabled)
    |=> $stable(inSleep_q) && $stable(inIdle_q) && !wakePulse_q) else $error("hold");
endmodule // psm_asserts
bind psm_power_save_ctrl psm_asserts u_chk (.*);

// File: sim/psm_core_model.sv
/* Core model issuing the power-save instruction.
   Assumes the controller's clock. */
`timescale 1ns/1ps
module psm_core_model(
  input  wire logic clk, cpuClkEn_q, req, op,
  output logic      powerSaveInstr = 1'h0,
  output logic      powerSaveOperand = 1'h0);
  // one-cycle instruction, only while core clock runs
  always @(negedge clk)
  begin
    powerSaveInstr <= req & cpuClkEn_q & ~powerSaveInstr;
    // Released operand toggles so a stale value is never trusted
    powerSaveOperand <= req ? op : ~powerSaveOperand;
  end
endmodule // psm_core_model

// File: sim/tb_top.sv
/* Testbench for the power-save controller.
   Assumes the core model and checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0, rst = 1'h1, req = 1'h0, op = 1'h0, intPending = 1'h0, intEnabled = 1'h0;
  logic wdtTimeout = 1'h0, oscCtrlWrite = 1'h0, cfgLocked = 1'h0, powerSaveInstr, powerSaveOperand;
  logic cpuClkEn_q, periphClkEn_q, sysClkEn_q, inSleep_q, inIdle_q, wakeIntService_q, wakePulse_q;
  logic oscWriteRefused;
  logic [15:0] oscCtrlWdata = 16'h0000;
  logic [2:0] newOscillatorSelect;
  // Row: op, woken by interrupt, sleep, idle, periph clock, service
  logic [5:0] rows [4] = '{6'h08, 6'h19, 6'h26, 6'h37};
  int failures = 0, check_count = 0;
  always #2.5 clk = ~clk;
  psm_core_model u_core (.*);
  psm_power_save_ctrl u_dut (.*);
  task automatic chk(input string n, input logic [7:0] e, s);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (200) @(posedge clk);
    failures++;
    final_report();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      {op, req} <= {rows[i][5], 1'h1};
      @(negedge clk) req <= 1'h0;
      @(negedge clk) chk("enter", {3'h0, rows[i][3:1], 1'h0, ~rows[i][3]}, {3'h0, inSleep_q, inIdle_q, periphClkEn_q, cpuClkEn_q, sysClkEn_q});
      {intPending, intEnabled, wdtTimeout} <= {rows[i][4], rows[i][4], ~rows[i][4]};
      @(negedge clk) chk("wake", 8'h01, {7'h00, wakePulse_q});
      {intPending, intEnabled, wdtTimeout} <= 3'h0;
      @(negedge clk) chk("resume", {6'h00, 1'h1, rows[i][0]}, {6'h00, cpuClkEn_q, wakeIntService_q});
      $display("row %0d done", i);
    end
    {oscCtrlWrite, oscCtrlWdata} <= {1'h1, 16'h0500};
    @(negedge clk) {cfgLocked, oscCtrlWdata} <= {1'h1, 16'h0300};
    chk("osc", 8'h05, {4'h0, oscWriteRefused, newOscillatorSelect});
    @(negedge clk) oscCtrlWrite <= 1'h0;
    chk("lock", 8'h0D, {4'h0, oscWriteRefused, newOscillatorSelect});
    $display("osc done");
    {op, req} <= 2'h1;
    @(negedge clk) req <= 1'h0;
    @(negedge clk) {intPending, intEnabled} <= 2'h2;
    @(negedge clk) chk("masked", 8'h02, {6'h00, inSleep_q, wakePulse_q});
    intPending <= 1'h0;
    $display("masked done");
    @(negedge clk) rst <= 1'h1;
    @(negedge clk) rst <= 1'h0;
    chk("reset", 8'h07, {newOscillatorSelect, inIdle_q, inSleep_q, cpuClkEn_q, periphClkEn_q, sysClkEn_q});
    $display("reset done");
    final_report();
  end
endmodule // tb_top

// File: src/psm_osc_sel.v
/*
  New-oscillator select field holder.
  Assumes writes come as one-cycle strobes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "psm_map.vh"

module psm_osc_sel
(
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    wrStb,
  input  wire [15:0]             wrData,
  input  wire                    cfgLocked,
  output reg  [`PSM_NOSC_W-1:0]  noscSel_q,
  output reg                     wrRefused_q
);

  always @(posedge clk)
  begin
    if (rst)
    begin
      noscSel_q   <= `PSM_NOSC_RST;
      wrRefused_q <= 1'h0;
    end
    else
    begin
      wrRefused_q <= wrStb & cfgLocked;
      if (wrStb && !cfgLocked)
      begin
        noscSel_q <= wrData[`PSM_NOSC_MSB:`PSM_NOSC_LSB];
      end
    end
  end

endmodule // psm_osc_sel

// File: src/psm_power_save_ctrl.v
/*
  Power-save mode controller: sleep and idle entry by instruction, wake-up
  on enabled interrupt, watchdog time-out or reset, and the new-oscillator
  select field guarded by the clock-configuration lock.
  Assumes the core pulses the instruction strobe for one cycle and stalls
  while its clock enable is low; wake sources come from logic on clk.
  WAKE_CYC sets how many cycles the core is held off after a wake event;
  a zero setting is treated as one, and the checker expects one.
*/
// Contract
// - Low-power states are entered only by the power-save instruction, whose operand picks sleep or idle.
// - Sleep stops the clocks and halts execution until a wake-up event.
// - Idle halts the processor while peripheral clocks keep running.
// - Either state is left on an enabled interrupt, a watchdog time-out or a reset.
// - The new-oscillator select field may be written only while the clock configuration is unlocked.
`timescale 1ns/1ps
`include "psm_map.vh"

module psm_power_save_ctrl
#(
  parameter [7:0] WAKE_CYC = `PSM_WAKE_CYC
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        powerSaveInstr,
  input  wire        powerSaveOperand,
  input  wire        intPending,
  input  wire        intEnabled,
  input  wire        wdtTimeout,
  input  wire        oscCtrlWrite,
  input  wire [15:0] oscCtrlWdata,
  input  wire        cfgLocked,
  output reg         cpuClkEn_q,
  output reg         periphClkEn_q,
  output reg         sysClkEn_q,
  output reg         inSleep_q,
  output reg         inIdle_q,
  output reg         wakeIntService_q,
  output reg         wakePulse_q,
  output wire [2:0]  newOscillatorSelect,
  output wire        oscWriteRefused
);

  // State codes
  localparam [1:0] ST_RUN    = `PSM_ST_RUN;
  localparam [1:0] ST_SLEEP  = `PSM_ST_SLEEP;
  localparam [1:0] ST_IDLE   = `PSM_ST_IDLE;
  localparam [1:0] ST_WAKE   = `PSM_ST_WAKE;
  // Last count of the wake state; zero still gives one wake cycle
  localparam [7:0] WAKE_LAST = (WAKE_CYC == 8'h00) ? 8'h00 : WAKE_CYC - 8'h01;

  // Sleep or idle
  function isLowPower;
    input [1:0] st;
    begin
      isLowPower = (st == ST_SLEEP) || (st == ST_IDLE);
    end
  endfunction

  // Every clock stopped
  function isStopped;
    input [1:0] st;
    begin
      isStopped = (st == ST_SLEEP);
    end
  endfunction

  // Wake hold-off has run out
  function wakeDone;
    input [7:0] cnt;
    begin
      wakeDone = (cnt == WAKE_LAST);
    end
  endfunction

  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [7:0] wakeCnt_q;
  reg  [7:0] wakeCnt_d;
  reg        wakeByInt_q;
  reg        wakeByInt_d;
  reg        cpuClkEn_d;
  reg        periphClkEn_d;
  reg        sysClkEn_d;
  reg        inSleep_d;
  reg        inIdle_d;
  reg        wakePulse_d;
  reg        wakeIntService_d;
  wire       intWake;
  wire       wakeEvent;

  assign intWake   = intPending & intEnabled;
  assign wakeEvent = intWake | wdtTimeout;

  always @*
  begin
    state_d   = state_q;
    wakeCnt_d = 8'h00;
    case (state_q)
      ST_RUN:
      begin
        if (powerSaveInstr)
        begin
          state_d = (powerSaveOperand == `PSM_OP_IDLE) ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_IDLE:
      begin
        if (wakeEvent)
        begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (wakeDone(wakeCnt_q))
        begin
          state_d = ST_RUN;
        end
        else
        begin
          wakeCnt_d = wakeCnt_q + 8'h01;
        end
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @*
  begin
    wakeByInt_d = wakeByInt_q;
    // Interrupt wins over a time-out in the same cycle, so the core vectors
    if (isLowPower(state_q) && wakeEvent)
    begin
      wakeByInt_d = intWake;
    end
  end

  // Outputs follow the next state so each flag lines up with the state it names
  always @*
  begin
    sysClkEn_d       = !isStopped(state_d);
    periphClkEn_d    = !isStopped(state_d);
    // clock back after wake; held off in the wake cycle so the core sees one clean restart
    cpuClkEn_d       = (state_d == ST_RUN);
    inSleep_d        = (state_d == ST_SLEEP);
    inIdle_d         = (state_d == ST_IDLE);
    wakePulse_d      = (state_d == ST_WAKE);
    wakeIntService_d = (state_q == ST_WAKE) && (state_d == ST_RUN) && wakeByInt_q;
  end

  // Reset is itself a wake source: every state falls back to run
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= ST_RUN;
      wakeCnt_q   <= 8'h00;
      wakeByInt_q <= 1'h0;
    end
    else
    begin
      state_q     <= state_d;
      wakeCnt_q   <= wakeCnt_d;
      wakeByInt_q <= wakeByInt_d;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cpuClkEn_q    <= 1'h1;
      periphClkEn_q <= 1'h1;
      sysClkEn_q    <= 1'h1;
    end
    else
    begin
      cpuClkEn_q    <= cpuClkEn_d;
      periphClkEn_q <= periphClkEn_d;
      sysClkEn_q    <= sysClkEn_d;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      inSleep_q        <= 1'h0;
      inIdle_q         <= 1'h0;
      wakePulse_q      <= 1'h0;
      wakeIntService_q <= 1'h0;
    end
    else
    begin
      inSleep_q        <= inSleep_d;
      inIdle_q         <= inIdle_d;
      wakePulse_q      <= wakePulse_d;
      wakeIntService_q <= wakeIntService_d;
    end
  end

  psm_osc_sel uOscSel
  (
    .clk         (clk),
    .rst         (rst),
    .wrStb       (oscCtrlWrite),
    .wrData      (oscCtrlWdata),
    .cfgLocked   (cfgLocked),
    .noscSel_q   (newOscillatorSelect),
    .wrRefused_q (oscWriteRefused)
  );

endmodule // psm_power_save_ctrl
